//--- verif/pin_model.sv
/*
  Board model of one 4-bit pin group.
  Assumes o is tied low for open-drain groups, so oe then pulls low.
*/
`timescale 1ns/1ps

module pin_model
  import port_pins_pkg::*;
(
  // Clock
  input  wire logic    clk,
  // Block side and board side
  input  wire nibble_t oe,
  input  wire nibble_t o,
  input  wire nibble_t pu,
  input  wire nibble_t ext,
  input  wire nibble_t en,
  output wire nibble_t pin
);
  logic tog_q = 1'b0;

  // A floating pin changes every cycle so a stale level never reads as valid.
  always @(posedge clk) tog_q <= ~tog_q;
  assign pin = (oe & o) | (~oe & en & ext) | (~oe & ~en & (pu | {4{tog_q}}));
endmodule

//--- verif/port_pins_assertions.sv
/*
  Checker for port_pins: directions, latch timing and pin events.
  Assumes it is bound into port_pins and sees its ports by name.
*/
`timescale 1ns/1ps

module port_pins_chk
  import port_pins_pkg::*;
(
  // Clock and reset
  input wire logic    clk,
  input wire logic    sys_rst,
  // Pins and pin drivers
  input wire nibble_t first_input_port,
  input wire nibble_t second_input_port,
  input wire nibble_t key_return_io_port_i,
  input wire nibble_t clock_output_io_port_oe,
  input wire nibble_t bitwise_io_port_o,
  input wire nibble_t open_drain_port_a_oe,
  // CPU side
  input wire logic    wr_out_bit_port,
  input wire logic    wr_out_od_a,
  input wire nibble_t wr_data,
  input wire logic    clk_port_dir_out,
  input wire logic    sel_edge_rise_1,
  input wire logic    key_flag_clr,
  // Events
  input wire logic    dual_edge_irq,
  input wire logic    selectable_edge_irq,
  input wire logic    rising_test_irq,
  input wire logic    key_test_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A strobe followed by the two edges the latch and its driver take.
  sequence s_write(logic stb);
    stb ##2 1'b1;
  endsequence

  a_bit_out_latch:
    assert property (s_write(wr_out_bit_port) |-> bitwise_io_port_o == $past(wr_data, 2))
    else $error("bit port drive value wrong");
  a_od_low_drive:
    assert property (s_write(wr_out_od_a) |-> open_drain_port_a_oe == ~$past(wr_data, 2))
    else $error("open drain pull low wrong");
  a_clk_dir_group:
    assert property (1'b1 |=> clock_output_io_port_oe == {4{$past(clk_port_dir_out)}})
    else $error("clock port direction not whole nibble");
  a_dual_edge_pulse:
    assert property ($changed(first_input_port[0]) |=> dual_edge_irq)
    else $error("dual edge pulse missing");
  a_rise_only:
    assert property (rising_test_irq |-> $past(second_input_port[2]) &&
                     !$past(second_input_port[2], 2))
    else $error("rising test pulse without rising edge");
  a_sel_edge_pulse:
    assert property ($changed(second_input_port[1]) &&
                     second_input_port[1] == sel_edge_rise_1 |=> selectable_edge_irq)
    else $error("selected edge pulse missing");
  a_key_flag_set:
    assert property (|($past(key_return_io_port_i) & ~key_return_io_port_i) |=> key_test_flag)
    else $error("key flag not set on falling key");
  a_key_flag_hold:
    assert property (key_test_flag && !key_flag_clr |=> key_test_flag)
    else $error("key flag dropped without clear");
endmodule

bind port_pins port_pins_chk u_chk (
  .clk, .sys_rst, .first_input_port, .second_input_port, .key_return_io_port_i,
  .clock_output_io_port_oe, .bitwise_io_port_o, .open_drain_port_a_oe, .wr_out_bit_port,
  .wr_out_od_a, .wr_data, .clk_port_dir_out, .sel_edge_rise_1, .key_flag_clr,
  .dual_edge_irq, .selectable_edge_irq, .rising_test_irq, .key_test_flag
);

//--- verif/tb_port_pins.sv
/*
  Self-checking bench for port_pins with a board model on every I/O group.
  Assumes the package, the checker and pin_model are compiled first.
*/
`timescale 1ns/1ps

module tb_port_pins
  import port_pins_pkg::*;
;
  logic         clk, sys_rst, subclock_test_in, wr_out_clk_port, wr_out_bit_port;
  logic         wr_out_key_port, wr_out_od_a, wr_out_od_b, clk_port_dir_out, first_pu_en;
  logic         clk_port_pu_en, bit_port_pu_en, key_port_pu_en, sel_edge_rise_0;
  logic         sel_edge_rise_1, key_flag_clr, timer_square_out, programmable_clock_out;
  logic         buzzer_out, timer_out_en, pclk_out_en, buzzer_en;
  nibble_t      first_input_port, second_input_port, analog_shared_input_port, wr_data;
  nibble_t      bit_port_dir, key_port_dir, ext[5], en[5];
  wire nibble_t oe[5], o[5], pu[5], pin[5], rd[8], first_input_port_pu;
  wire logic    [5:0] ev;
  wire logic    rd_subclock;
  int           mismatches = 0;
  int           tests_run = 0;

  always #4 clk = ~clk;
  assign o[3] = 4'h0;
  assign o[4] = 4'h0;
  for (genvar g = 0; g < 5; g++) begin : g_pin
    pin_model m (.clk, .oe(oe[g]), .o(o[g]), .pu(pu[g]), .ext(ext[g]), .en(en[g]), .pin(pin[g]));
  end

  port_pins #(.OD_PULL_B(4'h5)) dut (
    .clk, .sys_rst, .first_input_port, .second_input_port, .analog_shared_input_port,
    .subclock_test_in, .clock_output_io_port_i(pin[0]), .clock_output_io_port_o(o[0]),
    .clock_output_io_port_oe(oe[0]), .clock_output_io_port_pu(pu[0]),
    .bitwise_io_port_i(pin[1]), .bitwise_io_port_o(o[1]), .bitwise_io_port_oe(oe[1]),
    .bitwise_io_port_pu(pu[1]), .key_return_io_port_i(pin[2]), .key_return_io_port_o(o[2]),
    .key_return_io_port_oe(oe[2]), .key_return_io_port_pu(pu[2]), .first_input_port_pu,
    .open_drain_port_a_i(pin[3]), .open_drain_port_a_oe(oe[3]), .open_drain_port_a_pu(pu[3]),
    .open_drain_port_b_i(pin[4]), .open_drain_port_b_oe(oe[4]), .open_drain_port_b_pu(pu[4]),
    .wr_out_clk_port, .wr_out_bit_port, .wr_out_key_port, .wr_out_od_a, .wr_out_od_b,
    .wr_data, .clk_port_dir_out, .bit_port_dir, .key_port_dir, .first_pu_en, .clk_port_pu_en,
    .bit_port_pu_en, .key_port_pu_en, .sel_edge_rise_0, .sel_edge_rise_1, .key_flag_clr,
    .timer_square_out, .programmable_clock_out, .buzzer_out, .timer_out_en, .pclk_out_en,
    .buzzer_en, .rd_first_port(rd[0]), .rd_second_port(rd[1]), .rd_analog_port(rd[2]),
    .rd_clk_port(rd[3]), .rd_bit_port(rd[4]), .rd_key_port(rd[5]), .rd_od_a(rd[6]),
    .rd_od_b(rd[7]), .rd_subclock, .dual_edge_irq(ev[0]), .filtered_irq(ev[1]),
    .selectable_edge_irq(ev[2]), .rising_test_irq(ev[3]), .key_test_flag(ev[4]),
    .timer_event_pulse(ev[5])
  );

  task automatic check(input string nm, input nibble_t seen, input nibble_t exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Strobes stay up across back-to-back calls; a call with s of zero ends a burst.
  task automatic wr(input logic [4:0] s, input nibble_t d);
    {wr_out_clk_port, wr_out_bit_port, wr_out_key_port, wr_out_od_a, wr_out_od_b} = s;
    wr_data = d;
    cyc(1);
  endtask

  task automatic pulses(input int i, input nibble_t exp);
    nibble_t c;
    c = 4'h0;
    repeat (8) begin
      @(negedge clk);
      if (ev[i] === 1'b1) c++;
    end
    check("event pulses", c, exp);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 5; i++) check("oe after reset", oe[i], 4'h0);
    check("od pin", pin[3], 4'hF);
    check("od b pulls", pu[4], 4'h5);
    check("od a pulls", pu[3], 4'hF);
  endtask

  task automatic t_dir_pull();
    {clk_port_dir_out, bit_port_dir, key_port_dir} = 9'h1A6;
    {first_pu_en, clk_port_pu_en, bit_port_pu_en, key_port_pu_en} = 4'hF;
    cyc(1);
    check("clk oe", oe[0], 4'hF);
    check("bit oe", oe[1], 4'hA);
    check("key oe", oe[2], 4'h6);
    check("first pu", first_input_port_pu, 4'hE);
    check("clk pu", pu[0], 4'hF);
    check("io pu", pu[1] & pu[2], 4'hF);
    {clk_port_dir_out, bit_port_dir, key_port_dir} = 9'h0F0;
    {first_pu_en, clk_port_pu_en, bit_port_pu_en, key_port_pu_en} = 4'h0;
  endtask

  task automatic t_wr();
    wr(5'h08, 4'h5);
    wr(5'h08, 4'hA);
    check("bit o", o[1], 4'h5);
    wr(5'h03, 4'h3);
    check("bit o", o[1], 4'hA);
    wr(5'h00, 4'h0);
    check("od a oe", oe[3], 4'hC);
    check("od b pin", pin[4] & 4'h5, 4'h1);
    cyc(1);
    check("od a read", rd[6], 4'h3);
    check("bit read", rd[4], 4'hA);
    check("od b read", rd[7] & 4'h5, 4'h1);
    wr(5'h17, 4'h2);
    wr(5'h00, 4'h0);
    check("key o", o[2], 4'h2);
  endtask

  task automatic t_clk_out();
    clk_port_dir_out = 1'b1;
    {timer_out_en, pclk_out_en, buzzer_en} = 3'b111;
    {timer_square_out, programmable_clock_out, buzzer_out} = 3'b101;
    cyc(3);
    check("clk o", o[0], 4'hB);
    {timer_out_en, pclk_out_en, buzzer_en} = 3'b000;
    cyc(3);
    check("clk o", o[0], 4'h2);
    check("clk out read", rd[3], 4'h2);
    clk_port_dir_out = 1'b0;
  endtask

  task automatic t_rd();
    {first_input_port, analog_shared_input_port, bit_port_dir} = 12'h960;
    subclock_test_in = 1'b1;
    key_port_dir = 4'h3;
    ext[0] = 4'h6;
    cyc(2);
    check("first read", rd[0], 4'h9);
    check("analog read", rd[2], 4'h6);
    check("subclock read", {3'b000, rd_subclock}, 4'h1);
    check("bit in read", rd[4], 4'hC);
    check("key mixed read", rd[5], 4'hE);
    check("clk in read", rd[3], 4'h6);
    key_port_dir = 4'h0;
  endtask

  task automatic t_events();
    first_input_port = 4'h0;
    pulses(0, 4'h1);
    first_input_port = 4'h1;
    pulses(0, 4'h1);
    second_input_port = 4'h4;
    pulses(3, 4'h1);
    second_input_port = 4'h0;
    pulses(3, 4'h0);
    second_input_port = 4'h8;
    pulses(5, 4'h1);
    second_input_port = 4'hA;
    pulses(2, 4'h0);
    second_input_port = 4'h8;
    pulses(2, 4'h1);
    sel_edge_rise_1 = 1'b1;
    cyc(1);
    second_input_port = 4'hA;
    pulses(2, 4'h1);
    second_input_port = 4'hB;
    cyc(1);
    second_input_port = 4'hA;
    pulses(1, 4'h0);
    second_input_port = 4'hB;
    pulses(1, 4'h1);
    sel_edge_rise_0 = 1'b0;
    second_input_port = 4'hA;
    pulses(1, 4'h1);
    check("second read", rd[1], 4'hA);
  endtask

  task automatic t_keys();
    key_flag_clr = 1'b1;
    cyc(1);
    key_flag_clr = 1'b0;
    cyc(1);
    check("key flag", {3'b000, ev[4]}, 4'h0);
    ext[2] = 4'hB;
    cyc(2);
    check("key flag", {3'b000, ev[4]}, 4'h1);
    ext[2] = 4'hF;
    cyc(3);
    check("key flag", {3'b000, ev[4]}, 4'h1);
    ext[2] = 4'h7;
    key_flag_clr = 1'b1;
    cyc(1);
    key_flag_clr = 1'b0;
    cyc(2);
    check("key flag", {3'b000, ev[4]}, 4'h1);
  endtask

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {clk, subclock_test_in, wr_out_clk_port, wr_out_bit_port, wr_out_key_port, wr_out_od_a,
     wr_out_od_b, clk_port_dir_out, first_pu_en, clk_port_pu_en, bit_port_pu_en,
     key_port_pu_en, sel_edge_rise_1, key_flag_clr, timer_square_out, programmable_clock_out,
     buzzer_out, timer_out_en, pclk_out_en, buzzer_en} = '0;
    {sys_rst, sel_edge_rise_0} = 2'b11;
    {first_input_port, second_input_port, analog_shared_input_port} = 12'h000;
    {wr_data, bit_port_dir, key_port_dir} = 12'h000;
    ext = '{4'hF, 4'hC, 4'hF, 4'hF, 4'hF};
    en = '{4'hF, 4'hF, 4'hF, 4'h0, 4'h0};
    cyc(6);
    check("od pin in reset", pin[3], 4'hF);
    sys_rst = 1'b0;
    cyc(2);
    t_reset();
    t_dir_pull();
    t_wr();
    t_clk_out();
    t_rd();
    t_events();
    t_keys();
    summarize();
  end

  // A hang anywhere above ends the run here as a failure.
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule

//--- verilog/edge_filter.sv
/*
  Noise filter for one interrupt pin: a level must hold for a set number of
  cycles before the filtered output follows it.
  Assumes the input is synchronous to clk.
*/
`timescale 1ns/1ps

module edge_filter
  import port_pins_pkg::*;
#(
  parameter int CYCLES = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin in, clean level out
  input  wire logic raw_in,
  output logic      clean_out
);

  logic [7:0]    cnt_q;
  filter_state_t state_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= FLT_LOW;
      cnt_q     <= 8'h00;
      clean_out <= 1'b0;
    end else begin
      case (state_q)
        FLT_LOW: begin
          cnt_q <= 8'h00;
          if (raw_in) begin
            state_q <= FLT_RISE;
          end
        end
        FLT_RISE: begin
          // A level that changes before the count ends is a glitch.
          if (raw_in == clean_out) begin
            state_q <= clean_out ? FLT_HIGH : FLT_LOW;
          end else if (cnt_q >= 8'(CYCLES - 1)) begin
            clean_out <= raw_in;
            state_q   <= raw_in ? FLT_HIGH : FLT_LOW;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        FLT_HIGH: begin
          cnt_q <= 8'h00;
          if (!raw_in) begin
            state_q <= FLT_RISE;
          end
        end
        default: begin
          state_q <= FLT_LOW;
        end
      endcase
    end
  end

endmodule

//--- verilog/port_pins.sv
/*
  Pin-level port logic of a 4-bit controller: input ports, bidirectional
  ports, open-drain ports, pull-up enables and the shared event inputs.
  Assumes all pin inputs are synchronous to clk and that the CPU side
  presents write strobes as one-cycle pulses with data beside them.
  The pu outputs only ask the pad cells for a pull-up, and an open-drain
  pad pulls its pin low wherever the matching oe output is high.
*/
`timescale 1ns/1ps
`include "port_pins_map.svh"

// Operation
// - Input port zero; pull-ups in 3-bit group.
// - Input port one shares interrupt, timer inputs.
// - Clock port direction set all four bits.
// - Clock port pull-ups as one group.
// - Bitwise port has per-bit direction.
// - Per-bit direction, pull-ups per four bits.
// - Open-drain ports; pull-ups fixed by option.
// - Open-drain reset: high if pulled, else open.
// - Key-return port per-bit direction, analog shared.
// - Analog shared input-only port.
// - Filtered interrupt passes noise filter first.
// - Dual-edge interrupt fires on both edges.
// - Any key falling edge sets test flag.
// - Timer input passes event pulses to counter.
// - Subclock pin readable as test bit.
module port_pins
  import port_pins_pkg::*;
#(
  parameter nibble_t OD_PULL_A = 4'hF,
  parameter nibble_t OD_PULL_B = 4'hF,
  parameter int      FILT_CYC  = `FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pins: input-only ports
  input  wire nibble_t first_input_port,
  input  wire nibble_t second_input_port,
  input  wire nibble_t analog_shared_input_port,
  input  wire logic    subclock_test_in,
  // Pins: bidirectional ports
  input  wire nibble_t clock_output_io_port_i,
  output nibble_t      clock_output_io_port_o,
  output nibble_t      clock_output_io_port_oe,
  output nibble_t      clock_output_io_port_pu,
  input  wire nibble_t bitwise_io_port_i,
  output nibble_t      bitwise_io_port_o,
  output nibble_t      bitwise_io_port_oe,
  output nibble_t      bitwise_io_port_pu,
  input  wire nibble_t key_return_io_port_i,
  output nibble_t      key_return_io_port_o,
  output nibble_t      key_return_io_port_oe,
  output nibble_t      key_return_io_port_pu,
  output nibble_t      first_input_port_pu,
  // Pins: open-drain ports
  input  wire nibble_t open_drain_port_a_i,
  output nibble_t      open_drain_port_a_oe,
  output nibble_t      open_drain_port_a_pu,
  input  wire nibble_t open_drain_port_b_i,
  output nibble_t      open_drain_port_b_oe,
  output nibble_t      open_drain_port_b_pu,
  // CPU side: write strobes and data
  input  wire logic    wr_out_clk_port,
  input  wire logic    wr_out_bit_port,
  input  wire logic    wr_out_key_port,
  input  wire logic    wr_out_od_a,
  input  wire logic    wr_out_od_b,
  input  wire nibble_t wr_data,
  input  wire logic    clk_port_dir_out,
  input  wire nibble_t bit_port_dir,
  input  wire nibble_t key_port_dir,
  input  wire logic    first_pu_en,
  input  wire logic    clk_port_pu_en,
  input  wire logic    bit_port_pu_en,
  input  wire logic    key_port_pu_en,
  input  wire logic    sel_edge_rise_0,
  input  wire logic    sel_edge_rise_1,
  input  wire logic    key_flag_clr,
  // Shared peripheral outputs onto the clock port
  input  wire logic    timer_square_out,
  input  wire logic    programmable_clock_out,
  input  wire logic    buzzer_out,
  input  wire logic    timer_out_en,
  input  wire logic    pclk_out_en,
  input  wire logic    buzzer_en,
  // CPU side: read values
  output nibble_t      rd_first_port,
  output nibble_t      rd_second_port,
  output nibble_t      rd_analog_port,
  output nibble_t      rd_clk_port,
  output nibble_t      rd_bit_port,
  output nibble_t      rd_key_port,
  output nibble_t      rd_od_a,
  output nibble_t      rd_od_b,
  output logic         rd_subclock,
  // Events
  output logic         dual_edge_irq,
  output logic         filtered_irq,
  output logic         selectable_edge_irq,
  output logic         rising_test_irq,
  output logic         key_test_flag,
  output logic         timer_event_pulse
);

  nibble_t clk_out_q, bit_out_q, key_out_q, od_a_q, od_b_q;
  logic    dual_prev_q, filt_prev_q, sel_prev_q, rise_prev_q, tev_prev_q;
  nibble_t key_prev_q;
  logic    filt_clean;
  logic    key_fall;
  wire nibble_t key_fall_bits;

  // Output latches; open-drain latches reset high so the pin floats.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_out_q <= `OUT_RESET;
      bit_out_q <= `OUT_RESET;
      key_out_q <= `OUT_RESET;
      od_a_q    <= `OD_LATCH_RESET;
      od_b_q    <= `OD_LATCH_RESET;
    end else begin
      if (wr_out_clk_port) clk_out_q <= wr_data;
      if (wr_out_bit_port) bit_out_q <= wr_data;
      if (wr_out_key_port) key_out_q <= wr_data;
      if (wr_out_od_a) od_a_q <= wr_data;
      if (wr_out_od_b) od_b_q <= wr_data;
    end
  end

  // Pin directions; push-pull ports come out of reset as inputs.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_output_io_port_oe <= `DIR_RESET;
      bitwise_io_port_oe      <= `DIR_RESET;
      key_return_io_port_oe   <= `DIR_RESET;
      open_drain_port_a_oe    <= 4'h0;
      open_drain_port_b_oe    <= 4'h0;
    end else begin
      clock_output_io_port_oe <= {4{clk_port_dir_out}};
      bitwise_io_port_oe      <= bit_port_dir;
      key_return_io_port_oe   <= key_port_dir;
      // Open-drain drives only lows; a latch bit of one lets the pin go.
      open_drain_port_a_oe <= ~od_a_q;
      open_drain_port_b_oe <= ~od_b_q;
    end
  end

  // Drive values, registered so that a pin never sees a mux glitch.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_output_io_port_o <= `OUT_RESET;
      bitwise_io_port_o      <= `OUT_RESET;
      key_return_io_port_o   <= `OUT_RESET;
    end else begin
      // Peripheral functions override the latch on their own bits.
      clock_output_io_port_o <= {buzzer_en ? buzzer_out : clk_out_q[3],
                                 pclk_out_en ? programmable_clock_out : clk_out_q[2],
                                 clk_out_q[1],
                                 timer_out_en ? timer_square_out : clk_out_q[0]};
      bitwise_io_port_o    <= bit_out_q;
      key_return_io_port_o <= key_out_q;
    end
  end

  // Pull-up requests. The open-drain pull-ups are a fixed option, so they
  // stand through reset too and an undriven open-drain pin reads high where its OD_PULL_A or OD_PULL_B bit is set.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_input_port_pu     <= 4'h0;
      clock_output_io_port_pu <= 4'h0;
      bitwise_io_port_pu      <= 4'h0;
      key_return_io_port_pu   <= 4'h0;
      open_drain_port_a_pu    <= OD_PULL_A;
      open_drain_port_b_pu    <= OD_PULL_B;
    end else begin
      // Pull-ups are only useful on pins not being driven.
      first_input_port_pu     <= first_pu_en ? `FIRST_PULL_MASK : 4'h0;
      clock_output_io_port_pu <= clk_port_pu_en ? `FULL_PULL_MASK : 4'h0;
      bitwise_io_port_pu      <= bit_port_pu_en ? `FULL_PULL_MASK : 4'h0;
      key_return_io_port_pu   <= key_port_pu_en ? `FULL_PULL_MASK : 4'h0;
      open_drain_port_a_pu    <= OD_PULL_A;
      open_drain_port_b_pu    <= OD_PULL_B;
    end
  end

  // Read path: input ports read the pin whatever the shared function.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_first_port  <= 4'h0;
      rd_second_port <= 4'h0;
      rd_analog_port <= 4'h0;
      rd_clk_port    <= 4'h0;
      rd_bit_port    <= 4'h0;
      rd_key_port    <= 4'h0;
      rd_od_a        <= 4'h0;
      rd_od_b        <= 4'h0;
      rd_subclock    <= 1'b0;
    end else begin
      rd_first_port  <= first_input_port;
      rd_second_port <= second_input_port;
      rd_analog_port <= analog_shared_input_port;
      rd_clk_port    <= clk_port_dir_out ? clk_out_q : clock_output_io_port_i;
      rd_bit_port    <= (bit_port_dir & bit_out_q) | (~bit_port_dir & bitwise_io_port_i);
      rd_key_port    <= (key_port_dir & key_out_q) | (~key_port_dir & key_return_io_port_i);
      rd_od_a        <= open_drain_port_a_i;
      rd_od_b        <= open_drain_port_b_i;
      rd_subclock    <= subclock_test_in;
    end
  end

  edge_filter #(
    .CYCLES(FILT_CYC)
  ) u_filter (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .raw_in   (second_input_port[0]),
    .clean_out(filt_clean)
  );

  // One falling-edge term per key line; any of them sets the test flag.
  for (genvar k = 0; k < `PORT_WIDTH; k++) begin : g_key_fall
    assign key_fall_bits[k] = key_prev_q[k] & ~key_return_io_port_i[k];
  end
  assign key_fall = |key_fall_bits;

  // Edge event outputs are one-cycle pulses; key_test_flag holds until cleared. The previous-level registers reset
  // low, so a pin that idles high shows one rising edge after reset; the
  // interrupt side must clear that request before it enables the source.

  // Dual-edge interrupt: either change of the pin is a request.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dual_prev_q   <= 1'b0;
      dual_edge_irq <= 1'b0;
    end else begin
      dual_prev_q   <= first_input_port[0];
      dual_edge_irq <= first_input_port[0] ^ dual_prev_q;
    end
  end

  // Filtered interrupt: the edge is taken on the clean level only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_prev_q  <= 1'b0;
      filtered_irq <= 1'b0;
    end else begin
      filt_prev_q  <= filt_clean;
      filtered_irq <= sel_edge_rise_0 ? (filt_clean & ~filt_prev_q)
                                      : (~filt_clean & filt_prev_q);
    end
  end

  // Selectable-edge interrupt on the second pin of the port.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_prev_q          <= 1'b0;
      selectable_edge_irq <= 1'b0;
    end else begin
      sel_prev_q          <= second_input_port[1];
      selectable_edge_irq <= sel_edge_rise_1 ? (second_input_port[1] & ~sel_prev_q)
                                             : (~second_input_port[1] & sel_prev_q);
    end
  end

  // Rising-edge test input.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_prev_q     <= 1'b0;
      rising_test_irq <= 1'b0;
    end else begin
      rise_prev_q     <= second_input_port[2];
      rising_test_irq <= second_input_port[2] & ~rise_prev_q;
    end
  end

  // Timer event input: one count per rising edge of the pin.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tev_prev_q        <= 1'b0;
      timer_event_pulse <= 1'b0;
    end else begin
      tev_prev_q        <= second_input_port[3];
      timer_event_pulse <= second_input_port[3] & ~tev_prev_q;
    end
  end

  // Key lines, sampled once more so that a fall on any of them shows.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_prev_q <= 4'h0;
    end else begin
      key_prev_q <= key_return_io_port_i;
    end
  end

  // Key test flag: a fall in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_test_flag <= 1'b0;
    end else if (key_fall) begin
      key_test_flag <= 1'b1;
    end else if (key_flag_clr) begin
      key_test_flag <= 1'b0;
    end
  end

endmodule

//--- verilog/port_pins_map.svh
/*
  Constants for the port pin block: port widths, pull-up group masks, reset
  values and the noise filter length.
  Assumes inclusion by its bare name from the package and the design files.
*/
`ifndef PORT_PINS_MAP_SVH
`define PORT_PINS_MAP_SVH

`define PORT_WIDTH          4
`define FIRST_PULL_MASK     4'hE
`define FULL_PULL_MASK      4'hF
`define DIR_RESET           4'h0
`define OUT_RESET           4'h0
`define OD_LATCH_RESET      4'hF
`define FILTER_TIME_NS      16
`define CLK_PERIOD_NS       8
`define FILTER_CYCLES       ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/port_pins_pkg.sv
/*
  Types shared by the port pin block.
  Assumes port_pins_map.svh is on the include path.
*/
`include "port_pins_map.svh"

package port_pins_pkg;
  typedef logic [`PORT_WIDTH-1:0] nibble_t;
  typedef enum logic [2:0] {
    FLT_LOW  = 3'b001,
    FLT_RISE = 3'b010,
    FLT_HIGH = 3'b100
  } filter_state_t;
endpackage
